// >>> rtl/cskip_pkg.sv
// constants, register map and carriers for the compare-skip / decimal-adjust datapath
package cskip_pkg;

	localparam int unsigned CLK_PERIOD_NS = 5;

	// axi4-lite register map, byte addresses
	localparam logic [7:0]  OFS_CTRL     = 8'h00;
	localparam logic [7:0]  OFS_WREG     = 8'h04;
	localparam logic [7:0]  OFS_STATUS   = 8'h08;
	localparam logic [7:0]  OFS_BANKSEL  = 8'h0C;
	localparam logic [7:0]  OFS_MEM_ADDR = 8'h10;
	localparam logic [7:0]  OFS_MEM_DATA = 8'h14;
	localparam logic [7:0]  OFS_RESULT   = 8'h18;

	localparam int unsigned CTRL_TWO_WORD_BIT = 16;
	localparam int unsigned STAT_C_BIT        = 0;
	localparam int unsigned STAT_DC_BIT       = 1;
	localparam int unsigned RES_BUSY_BIT      = 0;
	localparam int unsigned RES_SKIP_BIT      = 1;
	localparam int unsigned RES_CYC_LO        = 2;

	localparam logic [7:0]  RST_WREG    = 8'h00;
	localparam logic [3:0]  RST_BANKSEL = 4'h0;
	localparam logic [11:0] RST_MEMADDR = 12'h000;

	// instruction encodings
	localparam logic [6:0]  OP_SKIP_GT  = 7'h32;
	localparam logic [6:0]  OP_SKIP_LT  = 7'h30;
	localparam logic [15:0] OP_DEC_ADJ  = 16'h0007;
	localparam int unsigned OPC_HI      = 15;
	localparam int unsigned OPC_LO      = 9;
	localparam int unsigned BANK_BIT    = 8;
	localparam int unsigned ACC_SPLIT   = 7;
	localparam logic [3:0]  ACC_LO_BANK = 4'h0;
	localparam logic [3:0]  ACC_HI_BANK = 4'hF;

	localparam logic [3:0]  BCD_LIMIT = 4'h9;
	localparam logic [3:0]  BCD_FIX   = 4'h6;
	localparam logic [1:0]  Q_LAST    = 2'h3;
	localparam logic [1:0]  SKIP_ONE  = 2'h1;
	localparam logic [1:0]  SKIP_TWO  = 2'h2;

	localparam logic [1:0]  RESP_OKAY   = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_SKIP} exec_state_e;

	typedef struct packed {
		logic        awvalid;
		logic [7:0]  awaddr;
		logic        wvalid;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        bready;
		logic        arvalid;
		logic [7:0]  araddr;
		logic        rready;
	} axil_req_s;

	typedef struct packed {
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} axil_rsp_s;

endpackage : cskip_pkg

// >>> rtl/compare_skip_decimal_adjust.sv
// compare-skip and decimal-adjust execution datapath with axi4-lite register access
//
// How it works
// RL1: skip next when file byte above working register
// RL2: less-than compare unsigned, flags and registers untouched
// RL3: taken skip discards fetched word, runs no-operation
// RL4: decode less-than as 0110000, bank, address
// RL5: skipping two-word instruction costs three cycles
// RL6: bank bit 0 access bank, 1 bank select
// RL7: low nibble above 9 or digit carry: add 6
// RL8: high nibble plus digit carry corrected likewise
// RL9: decimal adjust word 0007 finishes in one cycle
// RL10: decimal adjust changes only the carry flag
// RL11: greater-than variant shares cycles and bank meaning
//
// Added by the designer: the address map and the AXI4-Lite register port.
`timescale 1ns/10ps

module compare_skip_decimal_adjust (
	input  wire logic                  clk_sys_in,
	input  wire logic                  rst_n_in,
	input  wire cskip_pkg::axil_req_s  axil_req_in,
	output cskip_pkg::axil_rsp_s       axil_rsp_out,
	output logic                       busy_out
);

	logic                      awready_r;
	logic                      wready_r;
	logic                      bvalid_r;
	logic [1:0]                bresp_r;
	logic                      arready_r;
	logic                      rvalid_r;
	logic [31:0]               rdata_r;
	logic [1:0]                rresp_r;
	cskip_pkg::exec_state_e    state_r;
	logic [15:0]               instr_r;
	logic                      two_word_r;
	logic [7:0]                w_r;
	logic                      c_r;
	logic                      dc_r;
	logic [3:0]                bsr_r;
	logic [11:0]               mem_addr_r;
	logic [7:0]                file_mem [0:4095];
	logic [1:0]                q_r;
	logic [1:0]                skip_left_r;
	logic [1:0]                cycles_r;
	logic                      skip_r;
	logic                      aw_got_r;
	logic                      w_got_r;
	logic [7:0]                aw_addr_r;
	logic [31:0]               wdata_r;
	logic [3:0]                wstrb_r;
	logic [31:0]               wmask;
	logic [31:0]               rd_mux;
	logic                      rd_ok;

	// instruction decode
	wire [6:0]  opcode    = instr_r[cskip_pkg::OPC_HI:cskip_pkg::OPC_LO];
	wire        is_gt     = opcode == cskip_pkg::OP_SKIP_GT; // [RL1]
	wire        is_lt     = opcode == cskip_pkg::OP_SKIP_LT; // [RL4]
	wire        is_daw    = instr_r == cskip_pkg::OP_DEC_ADJ; // [RL9]
	wire [3:0]  acc_bank  = instr_r[cskip_pkg::ACC_SPLIT] ? cskip_pkg::ACC_HI_BANK
	                                                      : cskip_pkg::ACC_LO_BANK;
	wire [3:0]  bank      = instr_r[cskip_pkg::BANK_BIT] ? bsr_r : acc_bank; // [RL6] [RL11]
	wire [11:0] file_addr = {bank, instr_r[7:0]};
	wire [7:0]  file_byte = file_mem[file_addr];

	// unsigned subtraction, the difference itself is thrown away
	wire [8:0]  diff      = {1'b0, file_byte} - {1'b0, w_r}; // [RL2]
	wire        f_lt      = diff[8];
	wire        f_gt      = !diff[8] && (diff[7:0] != 8'h00);
	wire        skip_now  = (is_gt && f_gt) || (is_lt && f_lt); // [RL1] [RL2]

	// decimal adjust
	wire        lo_fix    = (w_r[3:0] > cskip_pkg::BCD_LIMIT) || dc_r; // [RL7]
	wire [3:0]  lo_new    = lo_fix ? w_r[3:0] + cskip_pkg::BCD_FIX : w_r[3:0]; // [RL7]
	wire [4:0]  hi_dc     = {1'b0, w_r[7:4]} + {4'h0, dc_r};
	wire [3:0]  hi_dc_lo4 = hi_dc[3:0];
	wire        hi_fix    = (hi_dc > {1'b0, cskip_pkg::BCD_LIMIT}) || c_r; // [RL8]
	wire [4:0]  hi_new    = hi_fix ? hi_dc + {1'b0, cskip_pkg::BCD_FIX} : hi_dc; // [RL8]
	// an incoming carry is kept so a prior overflow past 99 is not lost
	wire        c_new     = hi_new[4] | (hi_fix & c_r); // [RL10]

	wire        q_end     = (state_r != cskip_pkg::ST_IDLE) && (q_r == cskip_pkg::Q_LAST);
	wire        commit    = (state_r == cskip_pkg::ST_EXEC) && q_end;
	wire        idle      = state_r == cskip_pkg::ST_IDLE;

	// bus write decode
	wire        do_write  = aw_got_r && w_got_r && !bvalid_r;
	wire        wr_ctrl   = do_write && (aw_addr_r == cskip_pkg::OFS_CTRL);
	wire        wr_w      = do_write && (aw_addr_r == cskip_pkg::OFS_WREG);
	wire        wr_stat   = do_write && (aw_addr_r == cskip_pkg::OFS_STATUS);
	wire        wr_bsr    = do_write && (aw_addr_r == cskip_pkg::OFS_BANKSEL);
	wire        wr_maddr  = do_write && (aw_addr_r == cskip_pkg::OFS_MEM_ADDR);
	wire        wr_mdata  = do_write && (aw_addr_r == cskip_pkg::OFS_MEM_DATA);
	wire        wr_ok     = wr_ctrl || wr_w || wr_stat || wr_bsr || wr_maddr || wr_mdata
	                        || (aw_addr_r == cskip_pkg::OFS_RESULT);
	wire        start     = wr_ctrl && idle;
	wire [31:0] w_merge   = ({24'h0, w_r} & ~wmask) | (wdata_r & wmask);
	wire [31:0] st_merge  = ({30'h0, dc_r, c_r} & ~wmask) | (wdata_r & wmask);
	wire [31:0] bsr_merge = ({28'h0, bsr_r} & ~wmask) | (wdata_r & wmask);
	wire [31:0] ma_merge  = ({20'h0, mem_addr_r} & ~wmask) | (wdata_r & wmask);
	wire [31:0] md_merge  = ({24'h0, file_mem[mem_addr_r]} & ~wmask) | (wdata_r & wmask);
	wire [31:0] ct_merge  = ({15'h0, two_word_r, instr_r} & ~wmask) | (wdata_r & wmask);

	for (genvar i = 0; i < 4; i++) begin : g_lane
		assign wmask[i*8 +: 8] = {8{wstrb_r[i]}};
	end

	// read mux, unmapped answers slverr with zero data
	always_comb begin
		rd_mux = 32'h0000_0000;
		rd_ok  = 1'b1;
		case (axil_req_in.araddr)
			cskip_pkg::OFS_CTRL:     rd_mux = {15'h0, two_word_r, instr_r};
			cskip_pkg::OFS_WREG:     rd_mux = {24'h0, w_r};
			cskip_pkg::OFS_STATUS:   rd_mux = {30'h0, dc_r, c_r};
			cskip_pkg::OFS_BANKSEL:  rd_mux = {28'h0, bsr_r};
			cskip_pkg::OFS_MEM_ADDR: rd_mux = {20'h0, mem_addr_r};
			cskip_pkg::OFS_MEM_DATA: rd_mux = {24'h0, file_mem[mem_addr_r]};
			cskip_pkg::OFS_RESULT:   rd_mux = {28'h0, cycles_r, skip_r, busy_out};
			default:                 rd_ok  = 1'b0;
		endcase
	end

	// axi4-lite write channel
	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			aw_got_r  <= 1'h0;
			w_got_r   <= 1'h0;
			aw_addr_r <= 8'h00;
			wdata_r   <= 32'h0000_0000;
			wstrb_r   <= 4'h0;
			awready_r <= 1'h1;
			wready_r  <= 1'h1;
			bvalid_r  <= 1'h0;
			bresp_r   <= cskip_pkg::RESP_OKAY;
		end else begin
			if (axil_req_in.awvalid && awready_r) begin
				aw_got_r  <= 1'h1;
				aw_addr_r <= axil_req_in.awaddr;
				awready_r <= 1'h0;
			end
			if (axil_req_in.wvalid && wready_r) begin
				w_got_r  <= 1'h1;
				wdata_r  <= axil_req_in.wdata;
				wstrb_r  <= axil_req_in.wstrb;
				wready_r <= 1'h0;
			end
			if (do_write) begin
				aw_got_r <= 1'h0;
				w_got_r  <= 1'h0;
				bvalid_r <= 1'h1;
				bresp_r  <= wr_ok ? cskip_pkg::RESP_OKAY : cskip_pkg::RESP_SLVERR;
			end
			if (bvalid_r && axil_req_in.bready) begin
				bvalid_r  <= 1'h0;
				awready_r <= 1'h1;
				wready_r  <= 1'h1;
			end
		end
	end

	// axi4-lite read channel
	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			arready_r <= 1'h1;
			rvalid_r  <= 1'h0;
			rdata_r   <= 32'h0000_0000;
			rresp_r   <= cskip_pkg::RESP_OKAY;
		end else if (axil_req_in.arvalid && arready_r) begin
			arready_r <= 1'h0;
			rvalid_r  <= 1'h1;
			rdata_r   <= rd_mux;
			rresp_r   <= rd_ok ? cskip_pkg::RESP_OKAY : cskip_pkg::RESP_SLVERR;
		end else if (rvalid_r && axil_req_in.rready) begin
			arready_r <= 1'h1;
			rvalid_r  <= 1'h0;
		end
	end

	// separate flops per channel, so each response field has one driver
	assign axil_rsp_out = '{awready: awready_r, wready: wready_r, bvalid: bvalid_r,
	                        bresp: bresp_r, arready: arready_r, rvalid: rvalid_r,
	                        rdata: rdata_r, rresp: rresp_r};

	// data memory, no reset; software loads it while idle
	always_ff @(posedge clk_sys_in) begin
		if (wr_mdata && idle) begin
			file_mem[mem_addr_r] <= md_merge[7:0];
		end
	end

	// software state; operands are frozen while an instruction runs
	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			w_r        <= cskip_pkg::RST_WREG;
			c_r        <= 1'b0;
			dc_r       <= 1'b0;
			bsr_r      <= cskip_pkg::RST_BANKSEL;
			mem_addr_r <= cskip_pkg::RST_MEMADDR;
		end else begin
			if (commit && is_daw) begin
				w_r <= {hi_new[3:0], lo_new}; // [RL7] [RL8] [RL9]
				c_r <= c_new; // [RL10]
			end else if (idle) begin
				if (wr_w) begin
					w_r <= w_merge[7:0];
				end
				if (wr_stat) begin
					c_r  <= st_merge[cskip_pkg::STAT_C_BIT];
					dc_r <= st_merge[cskip_pkg::STAT_DC_BIT];
				end
				if (wr_bsr) begin
					bsr_r <= bsr_merge[3:0];
				end
			end
			if (wr_maddr) begin
				mem_addr_r <= ma_merge[11:0];
			end
		end
	end

	// instruction cycle sequencer, four quarter phases per cycle
	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			state_r     <= cskip_pkg::ST_IDLE;
			instr_r     <= 16'h0000;
			two_word_r  <= 1'b0;
			q_r         <= 2'h0;
			skip_left_r <= 2'h0;
			cycles_r    <= 2'h0;
			skip_r      <= 1'b0;
			busy_out    <= 1'b0;
		end else begin
			if (state_r != cskip_pkg::ST_IDLE) begin
				q_r <= q_r + 2'h1;
			end
			if (q_end) begin
				cycles_r <= cycles_r + 2'h1;
			end
			case (state_r)
				cskip_pkg::ST_IDLE: begin
					if (start) begin
						instr_r    <= ct_merge[15:0];
						two_word_r <= ct_merge[cskip_pkg::CTRL_TWO_WORD_BIT];
						q_r        <= 2'h0;
						cycles_r   <= 2'h0;
						skip_r     <= 1'b0;
						busy_out   <= 1'b1;
						state_r    <= cskip_pkg::ST_EXEC;
					end
				end
				cskip_pkg::ST_EXEC: begin
					if (q_end) begin
						skip_r <= skip_now; // [RL1] [RL2]
						if (skip_now) begin
							// fetched word(s) become no-operations
							skip_left_r <= two_word_r ? cskip_pkg::SKIP_TWO
							                          : cskip_pkg::SKIP_ONE; // [RL3] [RL5] [RL11]
							state_r     <= cskip_pkg::ST_SKIP;
						end else begin
							busy_out <= 1'b0;
							state_r  <= cskip_pkg::ST_IDLE;
						end
					end
				end
				cskip_pkg::ST_SKIP: begin
					if (q_end) begin
						skip_left_r <= skip_left_r - 2'h1;
						if (skip_left_r == cskip_pkg::SKIP_ONE) begin
							busy_out <= 1'b0;
							state_r  <= cskip_pkg::ST_IDLE;
						end
					end
				end
				default: begin
					busy_out <= 1'b0;
					state_r  <= cskip_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// checks
	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (!rst_n_in);

	wire gt_ref = file_byte > w_r;
	wire lt_ref = file_byte < w_r;
	wire [3:0] w_lo_ref = w_r[3:0];

	AST_GT_COND: assert property (commit && is_gt |=> skip_r == $past(gt_ref)) // [RL1]
		else $error("greater-than skip decision wrong");
	AST_LT_KEEP: assert property (commit && is_lt // [RL2]
		|=> $stable(w_r) && $stable(c_r) && $stable(dc_r))
		else $error("less-than compare altered state");
	AST_SKIP_ONE: assert property (commit && skip_now && !two_word_r // [RL3]
		|=> busy_out [*4] ##1 !busy_out)
		else $error("single skip not two cycles");
	AST_LT_COND: assert property (commit && is_lt |=> skip_r == $past(lt_ref)) // [RL4]
		else $error("less-than skip decision wrong");
	AST_SKIP_TWO: assert property (commit && skip_now && two_word_r // [RL5]
		|=> busy_out [*8] ##1 !busy_out)
		else $error("two-word skip not three cycles");
	AST_BANK_SEL: assert property (!idle && instr_r[cskip_pkg::BANK_BIT] // [RL6]
		|-> file_addr[11:8] == bsr_r)
		else $error("bank select not used");
	AST_DAW_LO: assert property (commit && is_daw && !lo_fix // [RL7]
		|=> w_r[3:0] == $past(w_lo_ref))
		else $error("low nibble changed without cause");
	AST_DAW_HI: assert property (commit && is_daw && !hi_fix // [RL8]
		|=> w_r[7:4] == $past(hi_dc_lo4))
		else $error("high nibble not plus digit carry");
	AST_DAW_CYC: assert property (start && ct_merge[15:0] == cskip_pkg::OP_DEC_ADJ // [RL9]
		|=> busy_out [*4] ##1 !busy_out)
		else $error("decimal adjust not one cycle");
	AST_DAW_FLAGS: assert property (commit && is_daw |=> $stable(dc_r) && $stable(bsr_r)) // [RL10]
		else $error("decimal adjust touched other flags");
	AST_GT_PATTERN: assert property (commit && is_gt && f_gt && two_word_r // [RL11]
		|=> skip_left_r == cskip_pkg::SKIP_TWO ##4 busy_out ##4 !busy_out)
		else $error("greater-than skip pattern wrong");

	COV_SKIP_ONE: cover property (commit && skip_now && !two_word_r);
	COV_SKIP_TWO: cover property (commit && skip_now && two_word_r);
	COV_NO_SKIP:  cover property (commit && (is_gt || is_lt) && !skip_now);
	COV_DAW_C:    cover property (commit && is_daw && c_new);

endmodule : compare_skip_decimal_adjust

// >>> test/test_compare_skip_decimal_adjust.sv
// self-checking testbench for the compare-skip / decimal-adjust datapath
`timescale 1ns/10ps

module test_compare_skip_decimal_adjust;

	logic                 clk_sys_in;
	logic                 rst_n_in;
	cskip_pkg::axil_req_s req;
	cskip_pkg::axil_rsp_s rsp;
	logic                 busy;
	logic [15:0]          lfsr_r;
	logic [7:0]           busy_cnt;
	logic [1:0]           bresp_seen;
	int                   fails;
	int                   checks_done;

	compare_skip_decimal_adjust u_dut (
		.clk_sys_in   (clk_sys_in),
		.rst_n_in     (rst_n_in),
		.axil_req_in  (req),
		.axil_rsp_out (rsp),
		.busy_out     (busy)
	);

	always #2.5 clk_sys_in = ~clk_sys_in;

	// busy length in clocks, cleared by the bench before each start
	always @(posedge clk_sys_in) if (busy === 1'h1) busy_cnt <= busy_cnt + 8'h01;

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : give_verdict

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			fails++;
			$display("BAD t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk

	task automatic hung();
		fails++;
		$display("BAD t=%0t wait limit got %h exp %h", $time, 32'h0, 32'h1);
		give_verdict();
	endtask : hung

	function automatic logic [15:0] lfsr_next(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : lfsr_next

	// two steps per draw, so neighbouring draws share fewer bits
	task automatic rnd(output logic [15:0] v);
		lfsr_r = lfsr_next(lfsr_next(lfsr_r));
		v = lfsr_r;
	endtask : rnd

	function automatic logic [3:0] skip_exp(input logic gt, input logic [7:0] f,
		input logic [7:0] w, input logic two);
		logic sk;
		sk = gt ? (f > w) : (f < w);
		return {sk ? (two ? 2'h3 : 2'h2) : 2'h1, sk, 1'h0};
	endfunction : skip_exp

	// returns {carry, adjusted working register}
	function automatic logic [8:0] daw_exp(input logic [7:0] w, input logic c, input logic dc);
		logic [3:0] lo;
		logic [4:0] hi;
		logic       fix;
		lo = (w[3:0] > 4'h9 || dc) ? w[3:0] + 4'h6 : w[3:0];
		hi = {1'h0, w[7:4]} + {4'h0, dc};
		fix = hi > 5'h09 || c;
		if (fix) hi = hi + 5'h06;
		return {hi[4] | (fix & c), hi[3:0], lo};
	endfunction : daw_exp

	// ready/valid looked at on the falling edge, acted on at the next rising edge
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
		logic aw_hit;
		logic w_hit;
		logic b_hit;
		int   n;
		req.awvalid <= 1'h1;
		req.awaddr <= a;
		req.wvalid <= 1'h1;
		req.wdata <= d;
		req.wstrb <= 4'hF;
		req.bready <= 1'h1;
		b_hit = 1'h0;
		for (n = 0; n < 50 && !b_hit; n++) begin
			@(negedge clk_sys_in);
			aw_hit = req.awvalid & rsp.awready;
			w_hit = req.wvalid & rsp.wready;
			b_hit = rsp.bvalid;
			bresp_seen = rsp.bresp;
			@(posedge clk_sys_in);
			if (aw_hit) req.awvalid <= 1'h0;
			if (w_hit) req.wvalid <= 1'h0;
			if (b_hit) req.bready <= 1'h0;
		end
		if (!b_hit) hung();
		// idle edge, so a following call never re-drives bready in this time step
		@(posedge clk_sys_in);
	endtask : axi_wr

	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
		logic ar_hit;
		logic r_hit;
		int   n;
		req.arvalid <= 1'h1;
		req.araddr <= a;
		req.rready <= 1'h1;
		r_hit = 1'h0;
		for (n = 0; n < 50 && !r_hit; n++) begin
			@(negedge clk_sys_in);
			ar_hit = req.arvalid & rsp.arready;
			r_hit = rsp.rvalid;
			d = rsp.rdata;
			resp = rsp.rresp;
			@(posedge clk_sys_in);
			if (ar_hit) req.arvalid <= 1'h0;
			if (r_hit) req.rready <= 1'h0;
		end
		if (!r_hit) hung();
		@(posedge clk_sys_in);
	endtask : axi_rd

	task automatic run_op(input logic [16:0] ctrl, output logic [31:0] res);
		logic [1:0] resp;
		int         n;
		@(negedge clk_sys_in);
		busy_cnt = 8'h00;
		@(posedge clk_sys_in);
		axi_wr(cskip_pkg::OFS_CTRL, {15'h0000, ctrl});
		for (n = 0; n < 40 && busy !== 1'h0; n++) @(posedge clk_sys_in);
		if (n == 40) hung();
		axi_rd(cskip_pkg::OFS_RESULT, res, resp);
	endtask : run_op

	initial begin
		logic [15:0] r;
		logic [15:0] r2;
		logic [31:0] d;
		logic [31:0] st;
		logic [31:0] res;
		logic [1:0]  resp;
		logic [7:0]  w;
		logic [7:0]  f;
		logic [7:0]  m;
		logic [3:0]  bs;
		logic        gt;
		logic        ba;
		logic        two;
		logic        c;
		logic        dc;
		logic [8:0]  e;
		int          i;
		clk_sys_in = 1'h0;
		rst_n_in = 1'h0;
		req = '0;
		lfsr_r = 16'h0057;
		busy_cnt = 8'h00;
		fails = 0;
		checks_done = 0;
		repeat (12) @(posedge clk_sys_in);
		rst_n_in <= 1'h1;
		@(posedge clk_sys_in);
		for (i = 0; i < 7; i++) begin
			if (i != 5) begin
				axi_rd(8'(i * 4), d, resp);
				chk(d, 32'h0);
				chk({30'h0, resp}, {30'h0, cskip_pkg::RESP_OKAY});
			end
		end
		axi_rd(8'h40, d, resp);
		chk({30'h0, resp}, {30'h0, cskip_pkg::RESP_SLVERR});
		chk(d, 32'h0);
		axi_wr(8'h40, 32'h0000_0001);
		chk({30'h0, bresp_seen}, {30'h0, cskip_pkg::RESP_SLVERR});
		// result is read-only: write answered okay, value unchanged
		axi_wr(cskip_pkg::OFS_RESULT, 32'h0000_000F);
		chk({30'h0, bresp_seen}, {30'h0, cskip_pkg::RESP_OKAY});
		axi_rd(cskip_pkg::OFS_RESULT, d, resp);
		chk(d, 32'h0);
		$display("reset and unmapped test done");
		for (i = 0; i < 32; i++) begin
			rnd(r);
			rnd(r2);
			{f, w} = r;
			{two, ba, gt, bs, m} = r2[14:0];
			if (i == 0) m = w;
			if (i == 1) {m, w} = 16'hFF00;
			// the byte is placed where the bank bit says the operand lives
			axi_wr(cskip_pkg::OFS_BANKSEL, {28'h0, bs});
			axi_wr(cskip_pkg::OFS_MEM_ADDR, {20'h0, ba ? bs : (f[7] ? 4'hF : 4'h0), f});
			axi_wr(cskip_pkg::OFS_MEM_DATA, {24'h0, m});
			axi_wr(cskip_pkg::OFS_WREG, {24'h0, w});
			axi_rd(cskip_pkg::OFS_STATUS, st, resp);
			run_op({two, gt ? cskip_pkg::OP_SKIP_GT : cskip_pkg::OP_SKIP_LT, ba, f}, res);
			chk({28'h0, res[3:0]}, {28'h0, skip_exp(gt, m, w, two)});
			chk({24'h0, busy_cnt}, {26'h0, skip_exp(gt, m, w, two) >> 2, 2'h0});
			axi_rd(cskip_pkg::OFS_WREG, d, resp);
			chk(d, {24'h0, w});
			axi_rd(cskip_pkg::OFS_STATUS, d, resp);
			chk(d, st);
		end
		$display("compare-skip test done");
		for (i = 0; i < 24; i++) begin
			rnd(r);
			{two, dc, c, w} = r[10:0];
			if (i == 0) {dc, c, w} = 10'h0A5;
			axi_wr(cskip_pkg::OFS_WREG, {24'h0, w});
			axi_wr(cskip_pkg::OFS_STATUS, {30'h0, dc, c});
			run_op({two, cskip_pkg::OP_DEC_ADJ}, res);
			e = daw_exp(w, c, dc);
			chk({28'h0, res[3:0]}, 32'h4);
			chk({24'h0, busy_cnt}, 32'h4);
			axi_rd(cskip_pkg::OFS_WREG, d, resp);
			chk(d, {24'h0, e[7:0]});
			axi_rd(cskip_pkg::OFS_STATUS, d, resp);
			chk(d, {30'h0, dc, e[8]});
		end
		$display("decimal adjust test done");
		give_verdict();
	end

endmodule : test_compare_skip_decimal_adjust
